// >>> inc/hsfr_pkg.sv
package hsfr_pkg;

  localparam int          NCH          = 2;
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 32;
  localparam int          CMP_W        = 7;

  localparam logic [7:0]  OFF_CTRL     = 8'h00;
  localparam logic [7:0]  OFF_STATUS   = 8'h04;
  localparam logic [7:0]  OFF_INT_STAT = 8'h08;
  localparam logic [7:0]  OFF_INT_MASK = 8'h0c;

  // control: tracking enable, then one software disable bit per channel
  localparam int          CTRL_TRACK   = 0;
  localparam int          CTRL_DIS_LSB = 1;
  localparam int          CTRL_W       = 3;
  localparam logic [2:0]  CTRL_RESET   = 3'h0;

  // status: one byte per channel, retry counters in the upper half
  localparam int          STAT_CH_W    = 8;
  localparam int          STAT_CNT_LSB = 16;

  // interrupt layout: timeout, severe trip, power good rising, one bit per channel each
  localparam int          INT_TMO_LSB  = 0;
  localparam int          INT_SEV_LSB  = 2;
  localparam int          INT_PGD_LSB  = 4;
  localparam int          INT_W        = 6;
  localparam logic [5:0]  INT_RESET    = 6'h00;

  localparam int          CNT_W        = 7;
  localparam logic [6:0]  RETRY_WAITS  = 7'h40;

  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_RAMP,
    ST_ON,
    ST_LATCHED,
    ST_WAIT_DIS,
    ST_WAIT_CHG
  } hsfr_state_e;

  // comparator and pin inputs of one channel
  typedef struct packed {
    logic enableN;
    logic overcurrentDetect;
    logic severeOvercurrent;
    logic timerDone;
    logic timerLow;
    logic rampDone;
    logic undervoltSense;
  } hsfr_cmp_s;

  // on/off controls and status pins of one channel
  typedef struct packed {
    logic gateDrive;
    logic gatePulldown;
    logic rampCharge;
    logic timerCharge;
    logic faultFlagN;
    logic powerGoodN;
  } hsfr_drv_s;

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == OFF_CTRL) || (a == OFF_STATUS) || (a == OFF_INT_STAT) || (a == OFF_INT_MASK);
  endfunction : reg_hit

endpackage : hsfr_pkg

// >>> logic/hsfr_sync.sv
`timescale 1ns/10ps
module hsfr_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] stage1;

  // two flops per bit; the first stage feeds only the second
  genvar b;
  for (b = 0; b < W; b++) begin : g_bit
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        stage1[b] <= 1'b0;
        dout[b]   <= 1'b0;
      end else begin
        stage1[b] <= din[b];
        dout[b]   <= stage1[b];
      end
    end
  end

endmodule : hsfr_sync

// >>> logic/hsfr_axil.sv
`timescale 1ns/10ps
module hsfr_axil (
  input  wire logic                         clk,
  input  wire logic                         rstn,
  input  wire logic [hsfr_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [hsfr_pkg::DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [hsfr_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [hsfr_pkg::DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  input  wire logic [hsfr_pkg::DATA_W-1:0]  rdData,
  output logic                              wrEn,
  output logic [hsfr_pkg::ADDR_W-1:0]       wrAddr,
  output logic [hsfr_pkg::DATA_W-1:0]       wrData,
  output logic [3:0]                        wrStrb
);

  logic                        awHeld, next_awHeld, wHeld, next_wHeld;
  logic [hsfr_pkg::ADDR_W-1:0] awAddr, next_awAddr, next_wrAddr;
  logic [hsfr_pkg::DATA_W-1:0] wData, next_wData, next_wrData, next_rdata;
  logic [3:0]                  wStrb, next_wStrb, next_wrStrb;
  logic                        next_awready, next_wready, next_bvalid, next_arready, next_rvalid, next_wrEn;
  logic [1:0]                  next_bresp, next_rresp;

  always_comb begin
    next_awHeld = awHeld;
    next_awAddr = awAddr;
    next_wHeld  = wHeld;
    next_wData  = wData;
    next_wStrb  = wStrb;
    next_bvalid = s_axi_bvalid;
    next_bresp  = s_axi_bresp;
    next_wrEn   = 1'b0;
    next_wrAddr = wrAddr;
    next_wrData = wrData;
    next_wrStrb = wrStrb;
    next_rvalid = s_axi_rvalid;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    // address and data are taken in either order, the write issues once both are held
    if (awHeld && wHeld && !s_axi_bvalid) begin
      next_wrEn   = hsfr_pkg::reg_hit(awAddr);
      next_wrAddr = awAddr;
      next_wrData = wData;
      next_wrStrb = wStrb;
      next_bvalid = 1'b1;
      next_bresp  = hsfr_pkg::reg_hit(awAddr) ? hsfr_pkg::RESP_OKAY : hsfr_pkg::RESP_SLVERR;
      next_awHeld = 1'b0;
      next_wHeld  = 1'b0;
    end
    if (s_axi_awvalid && s_axi_awready) begin
      next_awHeld = 1'b1;
      next_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_wHeld = 1'b1;
      next_wData = s_axi_wdata;
      next_wStrb = s_axi_wstrb;
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata  = rdData;
      next_rresp  = hsfr_pkg::reg_hit(s_axi_araddr) ? hsfr_pkg::RESP_OKAY : hsfr_pkg::RESP_SLVERR;
    end
    next_awready = !next_awHeld;
    next_wready  = !next_wHeld;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      awHeld        <= 1'b0;
      awAddr        <= '0;
      wHeld         <= 1'b0;
      wData         <= '0;
      wStrb         <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= hsfr_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= hsfr_pkg::RESP_OKAY;
      wrEn          <= 1'b0;
      wrAddr        <= '0;
      wrData        <= '0;
      wrStrb        <= 4'h0;
    end else begin
      awHeld        <= next_awHeld;
      awAddr        <= next_awAddr;
      wHeld         <= next_wHeld;
      wData         <= next_wData;
      wStrb         <= next_wStrb;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
      wrEn          <= next_wrEn;
      wrAddr        <= next_wrAddr;
      wrData        <= next_wrData;
      wrStrb        <= next_wrStrb;
    end
  end

endmodule : hsfr_axil

// >>> logic/hsfr_top.sv
`timescale 1ns/10ps
module hsfr_top #(
  parameter logic [hsfr_pkg::CNT_W-1:0] RETRY_WAITS = hsfr_pkg::RETRY_WAITS
) (
  input  wire logic                                    clk,
  input  wire logic                                    rstn,
  input  wire logic                                    porOk,
  input  wire logic                                    restartPolicySel,
  input  wire hsfr_pkg::hsfr_cmp_s [hsfr_pkg::NCH-1:0] chIn,
  output hsfr_pkg::hsfr_drv_s      [hsfr_pkg::NCH-1:0] chOut,
  output logic                                         irq,
  input  wire logic [hsfr_pkg::ADDR_W-1:0]             s_axi_awaddr,
  input  wire logic                                    s_axi_awvalid,
  output logic                                         s_axi_awready,
  input  wire logic [hsfr_pkg::DATA_W-1:0]             s_axi_wdata,
  input  wire logic [3:0]                              s_axi_wstrb,
  input  wire logic                                    s_axi_wvalid,
  output logic                                         s_axi_wready,
  output logic [1:0]                                   s_axi_bresp,
  output logic                                         s_axi_bvalid,
  input  wire logic                                    s_axi_bready,
  input  wire logic [hsfr_pkg::ADDR_W-1:0]             s_axi_araddr,
  input  wire logic                                    s_axi_arvalid,
  output logic                                         s_axi_arready,
  output logic [hsfr_pkg::DATA_W-1:0]                  s_axi_rdata,
  output logic [1:0]                                   s_axi_rresp,
  output logic                                         s_axi_rvalid,
  input  wire logic                                    s_axi_rready
);

  localparam int NCH = hsfr_pkg::NCH;
  localparam int SW  = NCH * hsfr_pkg::CMP_W + 2;

  hsfr_pkg::hsfr_cmp_s [NCH-1:0]         cmp;
  logic                                  porSync, policySync;
  hsfr_pkg::hsfr_state_e                 st [NCH];
  logic [hsfr_pkg::CNT_W-1:0]            waits [NCH];
  logic [NCH-1:0]                        evTmo, evSev, evPgd, enOk;
  logic [hsfr_pkg::CTRL_W-1:0]           ctrl, next_ctrl;
  logic [hsfr_pkg::INT_W-1:0]            intStat, next_intStat, intMask, next_intMask, intSet, intClr;
  logic                                  next_irq;
  logic [hsfr_pkg::DATA_W-1:0]           rdData;
  logic                                  wrEn;
  logic [hsfr_pkg::ADDR_W-1:0]           wrAddr;
  logic [hsfr_pkg::DATA_W-1:0]           wrData;
  logic [3:0]                            wrStrb;
  logic                                  trackEn;

  hsfr_sync #(
    .W (SW)
  ) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .din  ({porOk, restartPolicySel, chIn}),
    .dout ({porSync, policySync, cmp})
  );

  hsfr_axil u_axil (
    .clk           (clk),
    .rstn          (rstn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .rdData        (rdData),
    .wrEn          (wrEn),
    .wrAddr        (wrAddr),
    .wrData        (wrData),
    .wrStrb        (wrStrb)
  );

  assign trackEn = ctrl[hsfr_pkg::CTRL_TRACK];

  genvar i;
  for (i = 0; i < NCH; i++) begin : g_ch
    hsfr_pkg::hsfr_state_e      next_st;
    logic [hsfr_pkg::CNT_W-1:0] next_waits;
    hsfr_pkg::hsfr_drv_s        next_out;
    logic                       sevPrev, otherDown, sevEdge, next_tmo, next_run;

    // shared enable in tracking mode follows channel 0's pin
    assign enOk[i]   = porSync && !(trackEn ? cmp[0].enableN : cmp[i].enableN)
                       && !ctrl[hsfr_pkg::CTRL_DIS_LSB + i];
    assign otherDown = trackEn && (st[NCH-1-i] == hsfr_pkg::ST_LATCHED);
    assign sevEdge   = cmp[i].severeOvercurrent && !sevPrev;

    always_comb begin
      next_st    = st[i];
      next_waits = waits[i];
      next_tmo   = 1'b0;
      case (st[i])
        hsfr_pkg::ST_OFF: begin
          if (enOk[i]) begin
            next_st = hsfr_pkg::ST_RAMP;
          end
        end
        hsfr_pkg::ST_RAMP: begin
          if (cmp[i].rampDone) begin
            next_st = hsfr_pkg::ST_ON;
          end
        end
        hsfr_pkg::ST_ON: begin
          if (cmp[i].overcurrentDetect && cmp[i].timerDone) begin
            next_tmo   = 1'b1;
            next_waits = '0;
            next_st    = (policySync || trackEn) ? hsfr_pkg::ST_LATCHED : hsfr_pkg::ST_WAIT_DIS;
          end
        end
        hsfr_pkg::ST_LATCHED: begin
          next_st = hsfr_pkg::ST_LATCHED;
        end
        hsfr_pkg::ST_WAIT_DIS: begin
          if (cmp[i].timerLow) begin
            if (waits[i] == RETRY_WAITS) begin
              next_st    = hsfr_pkg::ST_RAMP;
              next_waits = '0;
            end else begin
              next_st = hsfr_pkg::ST_WAIT_CHG;
            end
          end
        end
        hsfr_pkg::ST_WAIT_CHG: begin
          if (cmp[i].timerDone) begin
            next_st    = hsfr_pkg::ST_WAIT_DIS;
            next_waits = waits[i] + 7'h01;
          end
        end
        default: begin
          next_st = hsfr_pkg::ST_OFF;
        end
      endcase
      if (otherDown && (st[i] == hsfr_pkg::ST_RAMP || st[i] == hsfr_pkg::ST_ON)) begin
        next_st = hsfr_pkg::ST_LATCHED;
      end
      if (!enOk[i]) begin
        next_st    = hsfr_pkg::ST_OFF;
        next_waits = '0;
        next_tmo   = 1'b0;
      end
      next_run              = (next_st == hsfr_pkg::ST_RAMP) || (next_st == hsfr_pkg::ST_ON);
      next_out.gateDrive    = next_run;
      next_out.rampCharge   = next_run;
      next_out.gatePulldown = next_run && sevEdge;
      next_out.timerCharge  = ((next_st == hsfr_pkg::ST_ON) && cmp[i].overcurrentDetect)
                              || (next_st == hsfr_pkg::ST_WAIT_CHG);
      next_out.faultFlagN   = (next_st == hsfr_pkg::ST_OFF) || next_run;
      next_out.powerGoodN   = !cmp[i].undervoltSense;
    end

    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        st[i]    <= hsfr_pkg::ST_OFF;
        waits[i] <= '0;
        sevPrev  <= 1'b0;
        evTmo[i] <= 1'b0;
        evSev[i] <= 1'b0;
        evPgd[i] <= 1'b0;
        chOut[i] <= '{gateDrive: 1'b0, gatePulldown: 1'b0, rampCharge: 1'b0, timerCharge: 1'b0,
                      faultFlagN: 1'b1, powerGoodN: 1'b1};
      end else begin
        st[i]    <= next_st;
        waits[i] <= next_waits;
        sevPrev  <= cmp[i].severeOvercurrent;
        evTmo[i] <= next_tmo;
        evSev[i] <= next_out.gatePulldown;
        evPgd[i] <= chOut[i].powerGoodN && !next_out.powerGoodN;
        chOut[i] <= next_out;
      end
    end

    property p_por_hold;
      @(posedge clk) disable iff (!rstn)
      !porSync |=> (st[i] == hsfr_pkg::ST_OFF) && !chOut[i].gateDrive && !chOut[i].rampCharge
                   && !chOut[i].timerCharge;
    endproperty
    a_por_hold: assert property (p_por_hold) else $error("channel not held off without bias");

    property p_ramp_timer;
      @(posedge clk) disable iff (!rstn)
      (st[i] == hsfr_pkg::ST_RAMP) |-> chOut[i].gateDrive && !chOut[i].timerCharge && chOut[i].faultFlagN;
    endproperty
    a_ramp_timer: assert property (p_ramp_timer) else $error("timer or fault active during ramp");

    property p_pgood;
      @(posedge clk) disable iff (!rstn)
      1'b1 |=> chOut[i].powerGoodN == !$past(cmp[i].undervoltSense);
    endproperty
    a_pgood: assert property (p_pgood) else $error("power good does not follow comparator");

    property p_oc_timer;
      @(posedge clk) disable iff (!rstn)
      (st[i] == hsfr_pkg::ST_ON) && enOk[i] && !otherDown && !cmp[i].timerDone
      |=> chOut[i].timerCharge == $past(cmp[i].overcurrentDetect) && chOut[i].gateDrive;
    endproperty
    a_oc_timer: assert property (p_oc_timer) else $error("timer does not follow overcurrent");

    property p_timeout;
      @(posedge clk) disable iff (!rstn)
      (st[i] == hsfr_pkg::ST_ON) && enOk[i] && cmp[i].overcurrentDetect && cmp[i].timerDone
      |=> !chOut[i].gateDrive && !chOut[i].rampCharge && !chOut[i].faultFlagN;
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout did not shut the channel");

    property p_latch;
      @(posedge clk) disable iff (!rstn)
      (st[i] == hsfr_pkg::ST_LATCHED) && enOk[i] |=> (st[i] == hsfr_pkg::ST_LATCHED) && !chOut[i].gateDrive;
    endproperty
    a_latch: assert property (p_latch) else $error("latched channel restarted while enabled");

    property p_retry;
      @(posedge clk) disable iff (!rstn)
      (st[i] == hsfr_pkg::ST_WAIT_DIS) && cmp[i].timerLow && (waits[i] == RETRY_WAITS) && enOk[i]
      |=> (st[i] == hsfr_pkg::ST_RAMP) && chOut[i].faultFlagN && chOut[i].gateDrive;
    endproperty
    a_retry: assert property (p_retry) else $error("retry not started after the wait cycles");

    property p_wait_early;
      @(posedge clk) disable iff (!rstn)
      (st[i] == hsfr_pkg::ST_WAIT_DIS) && (waits[i] != RETRY_WAITS) |=> !chOut[i].gateDrive;
    endproperty
    a_wait_early: assert property (p_wait_early) else $error("retry started before the wait ended");

    property p_severe;
      @(posedge clk) disable iff (!rstn)
      $rose(chOut[i].gatePulldown) |=> !chOut[i].gatePulldown;
    endproperty
    a_severe: assert property (p_severe) else $error("severe pulldown held longer than one cycle");

    property p_ramp_held;
      @(posedge clk) disable iff (!rstn)
      (st[i] == hsfr_pkg::ST_ON) |-> chOut[i].rampCharge && chOut[i].gateDrive;
    endproperty
    a_ramp_held: assert property (p_ramp_held) else $error("ramp not held charged when on");
  end

  property p_track;
    @(posedge clk) disable iff (!rstn)
    trackEn && (st[0] == hsfr_pkg::ST_LATCHED) && (st[1] == hsfr_pkg::ST_ON) |=> !chOut[1].gateDrive;
  endproperty
  a_track: assert property (p_track) else $error("tracking channel kept running");

  // registers; sticky interrupt bits take a new event over a clear in the same cycle
  always_comb begin
    next_ctrl    = ctrl;
    next_intMask = intMask;
    intClr       = '0;
    intSet       = '0;
    intSet[hsfr_pkg::INT_TMO_LSB +: NCH] = evTmo;
    intSet[hsfr_pkg::INT_SEV_LSB +: NCH] = evSev;
    intSet[hsfr_pkg::INT_PGD_LSB +: NCH] = evPgd;
    if (wrEn && wrStrb[0]) begin
      case (wrAddr)
        hsfr_pkg::OFF_CTRL:     next_ctrl    = wrData[hsfr_pkg::CTRL_W-1:0];
        hsfr_pkg::OFF_INT_MASK: next_intMask = wrData[hsfr_pkg::INT_W-1:0];
        hsfr_pkg::OFF_INT_STAT: intClr       = wrData[hsfr_pkg::INT_W-1:0];
        default:                next_ctrl    = ctrl;
      endcase
    end
    next_intStat = (intStat & ~intClr) | intSet;
    next_irq     = |(next_intStat & next_intMask);
  end

  always_comb begin
    rdData = '0;
    case (s_axi_araddr)
      hsfr_pkg::OFF_CTRL:     rdData[hsfr_pkg::CTRL_W-1:0] = ctrl;
      hsfr_pkg::OFF_INT_STAT: rdData[hsfr_pkg::INT_W-1:0]  = intStat;
      hsfr_pkg::OFF_INT_MASK: rdData[hsfr_pkg::INT_W-1:0]  = intMask;
      hsfr_pkg::OFF_STATUS: begin
        for (int c = 0; c < NCH; c++) begin
          rdData[c*hsfr_pkg::STAT_CH_W +: hsfr_pkg::STAT_CH_W] =
            {chOut[c].powerGoodN, chOut[c].faultFlagN, chOut[c].gateDrive, chOut[c].timerCharge,
             chOut[c].rampCharge, st[c]};
          rdData[hsfr_pkg::STAT_CNT_LSB + c*hsfr_pkg::STAT_CH_W +: hsfr_pkg::CNT_W] = waits[c];
        end
      end
      default: rdData = '0;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl    <= hsfr_pkg::CTRL_RESET;
      intStat <= hsfr_pkg::INT_RESET;
      intMask <= hsfr_pkg::INT_RESET;
      irq     <= 1'b0;
    end else begin
      ctrl    <= next_ctrl;
      intStat <= next_intStat;
      intMask <= next_intMask;
      irq     <= next_irq;
    end
  end

endmodule : hsfr_top

// >>> verif/hsfr_board.sv
`timescale 1ns/10ps
module hsfr_board #(
  parameter int T = 8
) (
  input  wire logic                      clk,
  input  wire hsfr_pkg::hsfr_drv_s [1:0] drv,
  input  wire logic [1:0]                enN,
  input  wire logic [1:0]                oc,
  input  wire logic [1:0]                sev,
  output hsfr_pkg::hsfr_cmp_s      [1:0] cmp
);
  int tmr[2] = '{0, 0};
  int ss[2]  = '{0, 0};
  // capacitor ramps: count up while charged, timer bleeds down, soft-start dumps at once
  always @(posedge clk) begin
    for (int c = 0; c < 2; c++) begin
      tmr[c] <= drv[c].timerCharge ? (tmr[c] < T ? tmr[c] + 1 : T) : (tmr[c] > 0 ? tmr[c] - 1 : 0);
      ss[c]  <= drv[c].rampCharge ? (ss[c] < T ? ss[c] + 1 : T) : 0;
    end
  end
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      cmp[c] = {enN[c], oc[c], sev[c], tmr[c] >= T, tmr[c] == 0, ss[c] >= T, ss[c] >= T && drv[c].gateDrive};
    end
  end
endmodule : hsfr_board

// >>> verif/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic                      clk = 1'b0, rstn = 1'b0, porOk = 1'b0, restartPolicySel = 1'b1, irq, prev;
  logic [1:0]                enN = 2'h3, oc = 2'h0, sev = 2'h0, s_axi_bresp, s_axi_rresp;
  hsfr_pkg::hsfr_cmp_s [1:0] chIn;
  hsfr_pkg::hsfr_drv_s [1:0] chOut;
  logic [7:0]                s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]               s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]                s_axi_wstrb = 4'hf;
  logic                      s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic                      s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic                      s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int                        fail_count = 0, n_checks = 0, n, k;
  always #2.5 clk = ~clk;
  hsfr_board u_board (.clk(clk), .drv(chOut), .enN(enN), .oc(oc), .sev(sev), .cmp(chIn));
  hsfr_top #(.RETRY_WAITS(7'h02)) uut (.*);
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic waitb(input int b, input logic v);
    int i;
    for (i = 0; i < 3000 && chOut[0][b] !== v; i++) @(posedge clk);
    if (i == 3000) begin
      fail_count++;
      results();
    end
    chk(chOut[0][b], v);
  endtask : waitb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 100 && s_axi_bvalid !== 1'b1; i++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (i == 100) begin
      fail_count++;
      results();
    end
    chk(i < 100, 1'b1);
    chk(s_axi_bresp, hsfr_pkg::RESP_OKAY);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    int i;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 100 && s_axi_rvalid !== 1'b1; i++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (i == 100) begin
      fail_count++;
      results();
    end
    chk(s_axi_rdata, e);
    chk(s_axi_rresp, r);
  endtask : rdc
  initial begin
    repeat (10) @(posedge clk);
    chk(chOut, 12'h0c3);
    rstn <= 1'b1;
    enN <= 2'h2;
    repeat (20) @(posedge clk);
    chk(chOut, 12'h0c3);
    rdc(8'h00, 32'h0, hsfr_pkg::RESP_OKAY);
    rdc(8'h10, 32'h0, hsfr_pkg::RESP_SLVERR);
    wr(8'h0c, 32'h11);
    porOk <= 1'b1;
    waitb(5, 1'b1);
    chk({chOut[0][2], chOut[0][1], chOut[1][5]}, 3'h2);
    waitb(0, 1'b0);
    repeat (3) @(posedge clk);
    chk(irq, 1'b1);
    wr(8'h08, 32'h10);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    sev <= 2'h1;
    waitb(4, 1'b1);
    sev <= 2'h0;
    waitb(4, 1'b0);
    waitb(5, 1'b1);
    oc <= 2'h1;
    waitb(2, 1'b1);
    oc <= 2'h0;
    waitb(2, 1'b0);
    chk({chOut[0][5], chOut[0][3], chOut[0][1]}, 3'h7);
    $display("test bring-up done");
    oc <= 2'h1;
    waitb(1, 1'b0);
    chk(chOut[0][5:2], 4'h0);
    repeat (3) @(posedge clk);
    chk(irq, 1'b1);
    wr(8'h08, 32'h01);
    repeat (40) @(posedge clk);
    chk({chOut[0][5], irq}, 2'h0);
    enN <= 2'h3;
    oc <= 2'h0;
    waitb(1, 1'b1);
    enN <= 2'h2;
    waitb(5, 1'b1);
    $display("test latch done");
    enN <= 2'h3;
    restartPolicySel <= 1'b0;
    oc <= 2'h1;
    repeat (10) @(posedge clk);
    enN <= 2'h2;
    waitb(1, 1'b0);
    k = 0;
    prev = 1'b0;
    for (n = 0; n < 3000 && chOut[0][1] !== 1'b1; n++) begin
      @(posedge clk);
      if (chOut[0][2] === 1'b1 && prev === 1'b0) k++;
      prev = chOut[0][2];
    end
    if (n == 3000) begin
      fail_count++;
      results();
    end
    chk(k, 2);
    waitb(1, 1'b1);
    waitb(1, 1'b0);
    $display("test retry done");
    enN <= 2'h3;
    oc <= 2'h0;
    wr(8'h00, 32'h1);
    enN <= 2'h2;
    waitb(5, 1'b1);
    chk(chOut[1][5], 1'b1);
    oc <= 2'h1;
    waitb(1, 1'b0);
    repeat (2) @(posedge clk);
    chk({chOut[1][5], chOut[1][1]}, 2'h0);
    repeat (40) @(posedge clk);
    chk({chOut[0][5], chOut[0][1]}, 2'h0);
    rdc(8'h04, 32'h8383, hsfr_pkg::RESP_OKAY);
    wr(8'h00, 32'h7);
    repeat (5) @(posedge clk);
    chk({chOut[0][1], chOut[1][1]}, 2'h3);
    $display("test tracking done");
    results();
  end
endmodule : tb_top
